//--- common/sfd_defs.svh
// Purpose: Constants for the serial flash instruction decoder
// Assumes: Core clock of 125 MHz samples the host serial clock
// Notes: Cycle counts are derived, never typed in by hand
`ifndef SFD_DEFS_SVH
`define SFD_DEFS_SVH

`define SFD_CLK_PERIOD_NS 8
// Least serial clock period in core cycles for a maximum rate, rounded up
`define SFD_MIN_CYC(mhz) ((1000 + (mhz) * `SFD_CLK_PERIOD_NS - 1) / ((mhz) * `SFD_CLK_PERIOD_NS))

`define SFD_FMAX_50_MHZ 50
`define SFD_FMAX_80_MHZ 80
`define SFD_FMAX_104_MHZ 104
`define SFD_FMAX_133_MHZ 133

`define SFD_INSTR_BITS 8
`define SFD_LANES_ONE 3'h1
`define SFD_LANES_TWO 3'h2
`define SFD_LANES_FOUR 3'h4
`define SFD_RELEASE_CODE 8'hff

`endif

//--- common/sfd_pkg.sv
// Purpose: Types shared by the serial flash instruction decoder
// Assumes: Constants live in sfd_defs.svh
// Notes: Command classes are one-hot so a handler needs one bit only
package sfd_pkg;

  typedef enum logic [10:0] {
    SFD_CL_NONE    = 11'h001,
    SFD_CL_READ    = 11'h002,
    SFD_CL_PROGRAM = 11'h004,
    SFD_CL_ERASE   = 11'h008,
    SFD_CL_REG_WR  = 11'h010,
    SFD_CL_REG_RD  = 11'h020,
    SFD_CL_IDENT   = 11'h040,
    SFD_CL_CONTROL = 11'h080,
    SFD_CL_SUSPEND = 11'h100,
    SFD_CL_RESET   = 11'h200,
    SFD_CL_RELEASE = 11'h400
  } sfd_class_t;

  typedef enum logic [3:0] {
    SFD_ST_IDLE   = 4'h1,
    SFD_ST_OPCODE = 4'h2,
    SFD_ST_BODY   = 4'h4,
    SFD_ST_IGNORE = 4'h8
  } sfd_state_t;

  typedef struct packed {
    sfd_class_t cls;
    logic wide;
    logic [2:0] lanes;
    logic ddr;
    logic nv;
    logic [7:0] min_per;
  } sfd_dec_t;

endpackage

//--- core/sfd_cmd_decoder.sv
// Purpose: Instruction decoder of a serial NOR flash, behind its serial pins
// Assumes: Host serial clock well below half the core clock; mode 0 or 3
// Notes: Rate checks see whole core cycles, so fast limits round to 1-2
`timescale 1ns/1ns
`include "sfd_defs.svh"

module sfd_cmd_decoder
  import sfd_pkg::*;
#(
  parameter int PER_W = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic data_line_zero,
  output logic cmd_valid_q,
  output logic [7:0] cmd_code_q,
  output sfd_class_t cmd_class_q,
  output logic wide_addr_q,
  output logic [2:0] data_lanes_q,
  output logic double_rate_q,
  output logic overspeed_q,
  output logic frame_end_q,
  output logic nv_array_cycle_q,
  output logic sw_reset_q,
  output logic clear_status_q,
  output logic mode_release_q
);

  localparam logic [7:0] PER_50 = 8'(`SFD_MIN_CYC(`SFD_FMAX_50_MHZ));
  localparam logic [7:0] PER_80 = 8'(`SFD_MIN_CYC(`SFD_FMAX_80_MHZ));
  localparam logic [7:0] PER_104 = 8'(`SFD_MIN_CYC(`SFD_FMAX_104_MHZ));
  localparam logic [7:0] PER_133 = 8'(`SFD_MIN_CYC(`SFD_FMAX_133_MHZ));

  if (PER_W < 4 || PER_W > 8) begin : g_bad_width
    $error("PER_W must lie between 4 and 8");
  end

  // Build one decode entry
  function automatic sfd_dec_t ent(sfd_class_t c, logic w, logic [2:0] l, logic d,
                                   logic n, logic [7:0] p);
    sfd_dec_t e;
    e = '{cls: c, wide: w, lanes: l, ddr: d, nv: n, min_per: p};
    return e;
  endfunction

  // Instruction table; anything absent, reserved codes included, decodes to none
  function automatic sfd_dec_t decode(logic [7:0] op);
    sfd_dec_t e;
    e = ent(SFD_CL_NONE, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
    case (op)
      8'h01: e = ent(SFD_CL_REG_WR, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b1, PER_133);
      8'h30: e = ent(SFD_CL_CONTROL, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'h02: e = ent(SFD_CL_PROGRAM, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'h12: e = ent(SFD_CL_PROGRAM, 1'b1, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'h03: e = ent(SFD_CL_READ, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_50);
      8'h13: e = ent(SFD_CL_READ, 1'b1, `SFD_LANES_ONE, 1'b0, 1'b0, PER_50);
      8'h0b: e = ent(SFD_CL_READ, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'h0c: e = ent(SFD_CL_READ, 1'b1, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'h0d: e = ent(SFD_CL_READ, 1'b0, `SFD_LANES_ONE, 1'b1, 1'b0, PER_80);
      8'h0e: e = ent(SFD_CL_READ, 1'b1, `SFD_LANES_ONE, 1'b1, 1'b0, PER_80);
      8'h32, 8'h38: e = ent(SFD_CL_PROGRAM, 1'b0, `SFD_LANES_FOUR, 1'b0, 1'b0, PER_80);
      8'h34: e = ent(SFD_CL_PROGRAM, 1'b1, `SFD_LANES_FOUR, 1'b0, 1'b0, PER_80);
      8'h3b: e = ent(SFD_CL_READ, 1'b0, `SFD_LANES_TWO, 1'b0, 1'b0, PER_104);
      8'h3c: e = ent(SFD_CL_READ, 1'b1, `SFD_LANES_TWO, 1'b0, 1'b0, PER_104);
      8'h6b: e = ent(SFD_CL_READ, 1'b0, `SFD_LANES_FOUR, 1'b0, 1'b0, PER_104);
      8'h6c: e = ent(SFD_CL_READ, 1'b1, `SFD_LANES_FOUR, 1'b0, 1'b0, PER_104);
      8'hbb: e = ent(SFD_CL_READ, 1'b0, `SFD_LANES_TWO, 1'b0, 1'b0, PER_104);
      8'hbc: e = ent(SFD_CL_READ, 1'b1, `SFD_LANES_TWO, 1'b0, 1'b0, PER_104);
      8'hbd: e = ent(SFD_CL_READ, 1'b0, `SFD_LANES_TWO, 1'b1, 1'b0, PER_80);
      8'hbe: e = ent(SFD_CL_READ, 1'b1, `SFD_LANES_TWO, 1'b1, 1'b0, PER_80);
      8'heb: e = ent(SFD_CL_READ, 1'b0, `SFD_LANES_FOUR, 1'b0, 1'b0, PER_104);
      8'hec: e = ent(SFD_CL_READ, 1'b1, `SFD_LANES_FOUR, 1'b0, 1'b0, PER_104);
      8'hed: e = ent(SFD_CL_READ, 1'b0, `SFD_LANES_FOUR, 1'b1, 1'b0, PER_80);
      8'hee: e = ent(SFD_CL_READ, 1'b1, `SFD_LANES_FOUR, 1'b1, 1'b0, PER_80);
      8'h60, 8'hc7: e = ent(SFD_CL_ERASE, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'hd8: e = ent(SFD_CL_ERASE, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'hdc: e = ent(SFD_CL_ERASE, 1'b1, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'h9f, 8'h90: e = ent(SFD_CL_IDENT, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'hab: e = ent(SFD_CL_IDENT, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_50);
      8'h41: e = ent(SFD_CL_REG_RD, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'h43: e = ent(SFD_CL_REG_WR, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b1, PER_133);
      8'h4a: e = ent(SFD_CL_REG_WR, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'ha6: e = ent(SFD_CL_REG_WR, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'ha7: e = ent(SFD_CL_REG_RD, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'h5a: e = ent(SFD_CL_IDENT, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      // Register reads of status, config, autoboot, bank, ECC, ASP, OTP, DYB, PERSISTENT_SECTOR_PROTECTION, password
      8'h05, 8'h07, 8'h35, 8'h14, 8'h16, 8'h18, 8'h2b, 8'h4b, 8'he0, 8'he2,
      8'he7: e = ent(SFD_CL_REG_RD, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      // Non-volatile register writes: autoboot, ASP, password
      8'h15, 8'h2f, 8'he8: e = ent(SFD_CL_REG_WR, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b1, PER_133);
      // Volatile or separate-array writes: bank, DYB, OTP, PERSISTENT_SECTOR_PROTECTION array
      8'h17, 8'hb9, 8'he1, 8'h42, 8'he3,
      8'he4: e = ent(SFD_CL_REG_WR, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'h04, 8'h06, 8'he9: e = ent(SFD_CL_CONTROL, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'h75, 8'h7a, 8'h85,
      8'h8a: e = ent(SFD_CL_SUSPEND, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'hf0: e = ent(SFD_CL_RESET, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      8'hff: e = ent(SFD_CL_RELEASE, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
      default: e = ent(SFD_CL_NONE, 1'b0, `SFD_LANES_ONE, 1'b0, 1'b0, PER_133);
    endcase
    return e;
  endfunction

  // Pin synchronisers; stage one feeds stage two only
  logic [2:0] sclk_sy_q;
  logic [2:0] cs_sy_q;
  logic [1:0] din_sy_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sclk_sy_q <= 3'h0;
      cs_sy_q <= 3'h7;
      din_sy_q <= 2'h0;
    end else begin
      sclk_sy_q <= {sclk_sy_q[1:0], sclk};
      cs_sy_q <= {cs_sy_q[1:0], cs_n};
      din_sy_q <= {din_sy_q[0], data_line_zero};
    end
  end

  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  assign sclk_rise = sclk_sy_q[1] & ~sclk_sy_q[2];
  assign cs_fall = ~cs_sy_q[1] & cs_sy_q[2];
  assign cs_rise = cs_sy_q[1] & ~cs_sy_q[2];

  // Frame state
  sfd_state_t state_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [7:0] opcode_d;
  logic last_bit;
  assign opcode_d = {shift_q, din_sy_q[1]};
  assign last_bit = (state_q == SFD_ST_OPCODE) && sclk_rise && (bit_cnt_q == 3'h7);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SFD_ST_IDLE;
    end else begin
      case (state_q)
        SFD_ST_IDLE: if (cs_fall) state_q <= SFD_ST_OPCODE;
        SFD_ST_OPCODE: begin
          if (cs_rise) state_q <= SFD_ST_IDLE;
          else if (last_bit) state_q <= SFD_ST_BODY;
        end
        SFD_ST_BODY: if (cs_rise) state_q <= SFD_ST_IDLE;
        SFD_ST_IGNORE: if (cs_rise) state_q <= SFD_ST_IDLE;
        default: state_q <= SFD_ST_IDLE;
      endcase
    end
  end

  // Opcode shifter, MSB first on rising serial clock
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
    end else if (cs_fall) begin
      bit_cnt_q <= 3'h0;
    end else if (state_q == SFD_ST_OPCODE && sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= opcode_d[6:0];
    end
  end

  // Serial clock period in core cycles, saturating
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] per_min_q;
  logic [PER_W-1:0] per_next;
  logic seen_edge_q;
  // Period ending at this rise; saturates so a slow clock never wraps into a short one
  assign per_next = (per_cnt_q == '1) ? per_cnt_q : per_cnt_q + 1'b1;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      per_cnt_q <= '0;
      per_min_q <= '1;
      seen_edge_q <= 1'b0;
    end else if (cs_fall) begin
      per_cnt_q <= '0;
      per_min_q <= '1;
      seen_edge_q <= 1'b0;
    end else if (sclk_rise) begin
      per_cnt_q <= '0;
      seen_edge_q <= 1'b1;
      if (seen_edge_q && per_next < per_min_q) begin
        per_min_q <= per_next;
      end
    end else if (per_cnt_q != '1) begin
      per_cnt_q <= per_cnt_q + 1'b1;
    end
  end

  // Decoded command outputs; the class clears as the next frame starts, code, width, lanes and rate hold to the next eighth bit
  sfd_dec_t dec;
  assign dec = decode(opcode_d);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cmd_valid_q <= 1'b0;
      cmd_code_q <= 8'h00;
      cmd_class_q <= SFD_CL_NONE;
      wide_addr_q <= 1'b0;
      data_lanes_q <= `SFD_LANES_ONE;
      double_rate_q <= 1'b0;
    end else begin
      cmd_valid_q <= last_bit && (dec.cls != SFD_CL_NONE);
      if (cs_fall) begin
        cmd_class_q <= SFD_CL_NONE;
      end else if (last_bit) begin
        cmd_code_q <= opcode_d;
        cmd_class_q <= dec.cls;
        wide_addr_q <= dec.wide;
        data_lanes_q <= dec.lanes;
        double_rate_q <= dec.ddr;
      end
    end
  end

  // Rate check: edges during the opcode and after it, against the code's limit
  logic [7:0] lim_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      lim_q <= PER_133;
      overspeed_q <= 1'b0;
    end else if (cs_fall) begin
      overspeed_q <= 1'b0;
    end else if (last_bit) begin
      lim_q <= dec.min_per;
      // The period ending at the eighth rise is not yet in the minimum, so it is checked here too
      overspeed_q <= (8'(per_min_q) < dec.min_per) || (8'(per_next) < dec.min_per);
    end else if (state_q == SFD_ST_BODY && sclk_rise && 8'(per_next) < lim_q) begin
      overspeed_q <= 1'b1;
    end
  end

  // Execute-at-deselect pulses; a frame cut short of eight bits does nothing
  logic done;
  sfd_dec_t held_dec;
  assign done = cs_rise && state_q == SFD_ST_BODY;
  assign held_dec = decode(cmd_code_q);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      frame_end_q <= 1'b0;
      nv_array_cycle_q <= 1'b0;
      sw_reset_q <= 1'b0;
      clear_status_q <= 1'b0;
      mode_release_q <= 1'b0;
    end else begin
      frame_end_q <= done && cmd_class_q != SFD_CL_NONE;
      nv_array_cycle_q <= done && held_dec.nv;
      sw_reset_q <= done && cmd_class_q == SFD_CL_RESET;
      clear_status_q <= done && cmd_code_q == 8'h30;
      mode_release_q <= done && cmd_code_q == `SFD_RELEASE_CODE;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_valid_at_eighth;
    last_bit && dec.cls != SFD_CL_NONE |=> cmd_valid_q && cmd_code_q == $past(opcode_d);
  endproperty
  a_valid_at_eighth: assert property (p_valid_at_eighth) else $error("no valid at bit eight");
  property p_reserved_quiet;
    last_bit && (opcode_d == 8'ha3 || opcode_d == 8'he5 || opcode_d == 8'he6) |=> !cmd_valid_q;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved code accepted");
  property p_alt_erase;
    cmd_valid_q && cmd_code_q == 8'hc7 |-> cmd_class_q == SFD_CL_ERASE && !wide_addr_q;
  endproperty
  a_alt_erase: assert property (p_alt_erase) else $error("alternate erase differs");
  property p_reset_at_deselect;
    sw_reset_q |-> $past(cs_rise) && $past(cmd_class_q) == SFD_CL_RESET;
  endproperty
  a_reset_at_deselect: assert property (p_reset_at_deselect) else $error("early reset");
  property p_nv_cycle_once;
    nv_array_cycle_q |=> !nv_array_cycle_q;
  endproperty
  a_nv_cycle_once: assert property (p_nv_cycle_once) else $error("double cycle");
  property p_quad_wide;
    cmd_valid_q && cmd_code_q == 8'hec |-> wide_addr_q && data_lanes_q == `SFD_LANES_FOUR;
  endproperty
  a_quad_wide: assert property (p_quad_wide) else $error("bad four-line read");
  property p_ddr_reads;
    cmd_valid_q && (cmd_code_q == 8'hbd || cmd_code_q == 8'hed) |-> double_rate_q && !wide_addr_q;
  endproperty
  a_ddr_reads: assert property (p_ddr_reads) else $error("double rate not flagged");
  property p_release;
    mode_release_q |-> $past(cmd_code_q) == `SFD_RELEASE_CODE && $past(cs_rise);
  endproperty
  a_release: assert property (p_release) else $error("stray release");
  property p_clear_status;
    clear_status_q |-> $past(cmd_class_q) == SFD_CL_CONTROL;
  endproperty
  a_clear_status: assert property (p_clear_status) else $error("stray status clear");
  property p_slow_read;
    last_bit && opcode_d == 8'h03 && per_min_q < PER_W'(PER_50) |=> overspeed_q;
  endproperty
  a_slow_read: assert property (p_slow_read) else $error("overspeed missed");

  c_read: cover property (cmd_valid_q && cmd_class_q == SFD_CL_READ);
  c_reset: cover property (sw_reset_q);
  c_over: cover property (overspeed_q && frame_end_q);
  c_nv: cover property (nv_array_cycle_q);

endmodule

//--- test/sfd_host_model.sv
// Purpose: Host side of the serial link that feeds the instruction decoder
// Assumes: Serial mode 0, clock idles low and stands still between frames
// Notes: Edges are placed on core clock edges, so phase is only varied by half period
`timescale 1ns/1ns

module sfd_host_model (
  input wire logic clock,
  output logic sclk,
  output logic cs_n,
  output logic data_line_zero
);
  // Deselected and idle from time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    data_line_zero = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One frame, MSB first; the data line toggles away once released so it never looks held
  task automatic frame(input logic [31:0] word, input int nbits, input int half, input int gap);
    logic last;
    int h;
    last = 1'b0;
    h = (half < 1) ? 1 : half; // One cycle per level breaks the 50 MHz limit on purpose
    @(posedge clock);
    cs_n <= 1'b0;
    wait_clk(h);
    for (int i = nbits - 1; i >= 0; i--) begin
      data_line_zero <= word[i]; // Eight ones here form the release command
      last = word[i];
      wait_clk(h);
      sclk <= 1'b1;
      wait_clk(h);
      sclk <= 1'b0;
    end
    data_line_zero <= ~last;
    wait_clk(h);
    cs_n <= 1'b1;
    wait_clk(gap);
  endtask
endmodule

//--- test/tb.sv
// Purpose: Self-checking bench for the serial flash instruction decoder
// Assumes: Core clock 125 MHz, host serial clock at 80 ns unless randomised or set to 32 ns or 16 ns
// Notes: Every code is sent once, then random frames with trailing bits
`timescale 1ns/1ns
`include "sfd_defs.svh"

module tb
  import sfd_pkg::*;
;
  logic clock, reset_n, sclk, cs_n, data_line_zero;
  logic cmd_valid_q, wide_addr_q, double_rate_q, overspeed_q, frame_end_q;
  logic nv_array_cycle_q, sw_reset_q, clear_status_q, mode_release_q;
  logic [7:0] cmd_code_q, cap_code;
  logic [2:0] data_lanes_q, cap_lanes;
  logic cap_wide, cap_ddr;
  sfd_class_t cmd_class_q, cap_cls;
  int bad_count = 0, n_tests = 0, n_valid = 0, cycles = 0;
  int n_pulse [5];
  integer seed;
  int nb, hf;

  sfd_host_model host (.clock(clock), .sclk(sclk), .cs_n(cs_n),
    .data_line_zero(data_line_zero));

  sfd_cmd_decoder #(.PER_W(8)) dut (.clock(clock), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .data_line_zero(data_line_zero), .cmd_valid_q(cmd_valid_q),
    .cmd_code_q(cmd_code_q), .cmd_class_q(cmd_class_q), .wide_addr_q(wide_addr_q),
    .data_lanes_q(data_lanes_q), .double_rate_q(double_rate_q),
    .overspeed_q(overspeed_q), .frame_end_q(frame_end_q),
    .nv_array_cycle_q(nv_array_cycle_q), .sw_reset_q(sw_reset_q),
    .clear_status_q(clear_status_q), .mode_release_q(mode_release_q));

  // Core clock, 8 ns
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic is_def(input logic [7:0] c);
    return c inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0b, 8'h0c, 8'h0d,
      8'h0e, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h2b, 8'h2f, 8'h30, 8'h32,
      8'h34, 8'h35, 8'h38, 8'h3b, 8'h3c, 8'h41, 8'h42, 8'h43, 8'h4a, 8'h4b, 8'h5a, 8'h60,
      8'h6b, 8'h6c, 8'h75, 8'h7a, 8'h85, 8'h8a, 8'h90, 8'h9f, 8'ha6, 8'ha7, 8'hab, 8'hb9,
      8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hc7, 8'hd8, 8'hdc, 8'he0, 8'he1, 8'he2, 8'he3, 8'he4,
      8'he7, 8'he8, 8'he9, 8'heb, 8'hec, 8'hed, 8'hee, 8'hf0, 8'hff};
  endfunction

  function automatic logic is_read(input logic [7:0] c);
    return c inside {8'h03, 8'h13, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h3b, 8'h3c, 8'h6b, 8'h6c,
      8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'heb, 8'hec, 8'hed, 8'hee};
  endfunction

  function automatic logic [2:0] exp_lanes(input logic [7:0] c);
    if (c inside {8'h3b, 8'h3c, 8'hbb, 8'hbc, 8'hbd, 8'hbe}) return `SFD_LANES_TWO;
    if (c inside {8'h6b, 8'h6c, 8'heb, 8'hec, 8'hed, 8'hee, 8'h32, 8'h34, 8'h38})
      return `SFD_LANES_FOUR;
    return `SFD_LANES_ONE;
  endfunction

  // Handler class of every listed code; anything else is none
  function automatic sfd_class_t exp_class(input logic [7:0] c);
    if (is_read(c)) return SFD_CL_READ;
    if (c inside {8'h02, 8'h12, 8'h32, 8'h34, 8'h38}) return SFD_CL_PROGRAM;
    if (c inside {8'h60, 8'hc7, 8'hd8, 8'hdc}) return SFD_CL_ERASE;
    if (c inside {8'h01, 8'h43, 8'h4a, 8'ha6, 8'h15, 8'h2f, 8'he8, 8'h17, 8'hb9, 8'he1,
      8'h42, 8'he3, 8'he4}) return SFD_CL_REG_WR;
    if (c inside {8'h41, 8'ha7, 8'h05, 8'h07, 8'h35, 8'h14, 8'h16, 8'h18, 8'h2b, 8'h4b,
      8'he0, 8'he2, 8'he7}) return SFD_CL_REG_RD;
    if (c inside {8'h9f, 8'h90, 8'hab, 8'h5a}) return SFD_CL_IDENT;
    if (c inside {8'h30, 8'h04, 8'h06, 8'he9}) return SFD_CL_CONTROL;
    if (c inside {8'h75, 8'h7a, 8'h85, 8'h8a}) return SFD_CL_SUSPEND;
    if (c == 8'hf0) return SFD_CL_RESET;
    if (c == 8'hff) return SFD_CL_RELEASE;
    return SFD_CL_NONE;
  endfunction

  // Least legal serial clock period in core cycles for a code
  function automatic int exp_min_per(input logic [7:0] c);
    if (c inside {8'h03, 8'h13, 8'hab}) return `SFD_MIN_CYC(`SFD_FMAX_50_MHZ);
    if (c inside {8'h0d, 8'h0e, 8'h32, 8'h34, 8'h38, 8'hbd, 8'hbe, 8'hed, 8'hee})
      return `SFD_MIN_CYC(`SFD_FMAX_80_MHZ);
    if (c inside {8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec})
      return `SFD_MIN_CYC(`SFD_FMAX_104_MHZ);
    return `SFD_MIN_CYC(`SFD_FMAX_133_MHZ);
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Capture every one-cycle output seen during a frame
  always @(posedge clock) begin
    if (cmd_valid_q === 1'b1) begin
      n_valid++;
      cap_code = cmd_code_q;
      cap_cls = cmd_class_q;
      cap_wide = wide_addr_q;
      cap_lanes = data_lanes_q;
      cap_ddr = double_rate_q;
    end
    if (frame_end_q === 1'b1) n_pulse[0]++;
    if (nv_array_cycle_q === 1'b1) n_pulse[1]++;
    if (sw_reset_q === 1'b1) n_pulse[2]++;
    if (clear_status_q === 1'b1) n_pulse[3]++;
    if (mode_release_q === 1'b1) n_pulse[4]++;
  end

  // Hang guard, well above the expected run of about 34000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      give_verdict();
    end
  end

  // Send one frame and compare everything it should have caused
  task automatic run_frame(input logic [31:0] word, input int nbits, input int half);
    logic [7:0] c;
    logic ok, fast;
    int hh;
    n_valid = 0;
    n_pulse = '{default: 0};
    host.frame(word, nbits, half, 3);
    repeat (6) @(posedge clock);
    c = (nbits >= 8) ? 8'(word >> (nbits - 8)) : 8'h00;
    ok = (nbits >= 8) && is_def(c);
    hh = (half < 1) ? 1 : half; // Same floor as the host model
    fast = (nbits >= 8) && (2 * hh < exp_min_per(c));
    check("valid count", 32'(ok), 32'(n_valid));
    check("frame end count", 32'(ok), 32'(n_pulse[0]));
    check("nv cycle count", 32'(ok && (c inside {8'h01, 8'h43, 8'h15, 8'h2f, 8'he8})),
      32'(n_pulse[1]));
    check("sw reset count", 32'(ok && c == 8'hf0), 32'(n_pulse[2]));
    check("clear status count", 32'(ok && c == 8'h30), 32'(n_pulse[3]));
    check("release count", 32'(ok && c == 8'hff), 32'(n_pulse[4]));
    check("overspeed", 32'(fast), 32'(overspeed_q));
    if (ok) check("code", 32'(c), 32'(cap_code));
    if (ok) begin
      check("class", 32'(exp_class(c)), 32'(cap_cls));
      check("wide", 32'(c inside {8'h0c, 8'h0e, 8'h12, 8'h13, 8'h34, 8'h3c, 8'h6c, 8'hbc,
        8'hbe, 8'hec, 8'hee, 8'hdc}), 32'(cap_wide));
      check("lanes", 32'(exp_lanes(c)), 32'(cap_lanes));
      check("ddr", 32'(c inside {8'h0d, 8'h0e, 8'hbd, 8'hbe, 8'hed, 8'hee}),
        32'(cap_ddr));
    end
    if (nbits >= 8 && !is_def(c)) check("idle class", 32'(SFD_CL_NONE), 32'(cmd_class_q));
  endtask

  // Main sequence
  initial begin
    seed = 32'hd6353212;
    reset_n = 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    // Every code, including the reserved ones
    for (int i = 0; i < 256; i++) run_frame(32'(i), 8, 5);
    // Select rises one bit short of an opcode
    run_frame(32'h78, 7, 5);
    run_frame(32'h7f, 7, 2);
    // Trailing bits after the opcode are not part of it
    run_frame(32'hf0ff, 16, 2);
    repeat (60) begin
      nb = 8 + int'($unsigned($random(seed)) % 17);
      hf = 2 + int'($unsigned($random(seed)) % 4);
      run_frame($random(seed), nb, hf);
    end
    // Hardware reset between frames, then a software reset
    run_frame(32'heb, 8, 5);
    // Serial clock of two core cycles: only the 50 MHz codes are too fast for it
    run_frame(32'h0b, 8, 1);
    run_frame(32'hbd, 8, 1);
    run_frame(32'hab, 8, 1);
    run_frame(32'h13ff, 16, 1);
    run_frame(32'h03, 8, 1);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    check("reset overspeed", 32'h0, 32'(overspeed_q));
    check("reset code", 32'h0, 32'(cmd_code_q));
    check("reset class", 32'(SFD_CL_NONE), 32'(cmd_class_q));
    check("reset lanes", 32'(`SFD_LANES_ONE), 32'(data_lanes_q));
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    run_frame(32'hf0, 8, 5);
    give_verdict();
  end
endmodule
